// ---- hw/cts_top.sv ----
// register file, unit dividers and the two timer channels
// assumes an avalon-mm master on clk; all pins synchronous
`timescale 1ns/1ps
module cts_top
   import cts_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic compare_a_irq,
   output logic overflow_irq,
   output logic adc_start
);
   typedef struct packed {
      logic wreq;
      logic [31:0] rdata;
      logic [15:0] clk_div;
      logic [7:0] mod_stop;
      logic [7:0] p_ctrl;
      logic [7:0] p_mode;
      logic [15:0] p_cmp;
      logic [7:0] p_io_hi;
      logic [7:0] p_io_lo;
      logic [7:0] p_ie;
      logic [7:0] p_ie2;
      logic [7:0] slow_start;
      logic [7:0] s_ctrl;
      logic [7:0] s_mode;
      logic [7:0] fast_start;
      logic [7:0] sync_clr;
      logic [7:0] sync_op;
      logic flag_a;
      logic flag_ovf;
      logic arm_a;
      logic arm_ovf;
      logic [2:0] fast_div;
      logic [2:0] slow_div;
      logic fast_en;
      logic slow_en;
      logic irq_a;
      logic irq_ovf;
      logic adc;
   } cts_top_state_type;

   cts_top_state_type st_ff;
   cts_top_state_type nxt_st;

   logic [15:0] p_count;
   logic [15:0] s_count;
   logic p_match;
   logic p_ovf;
   logic s_clear;
   logic commit;
   logic wr_commit;
   logic rd_commit;
   logic p_cnt_wr;
   logic s_cnt_wr;
   logic [15:0] wdata16;
   logic [7:0] wdata8;

   // request is taken at the edge where waitrequest is low
   assign commit = (avs_read || avs_write) && !st_ff.wreq;
   assign wr_commit = commit && avs_write;
   assign rd_commit = commit && avs_read;

   // byte-lane merge for the low half word
   always_comb begin
      wdata16 = 16'h0000;
      wdata8 = avs_writedata[7:0];
      case (avs_address)
         OFS_CLK_DIV: wdata16 = st_ff.clk_div;
         OFS_P_COUNT: wdata16 = p_count;
         OFS_P_CMP_A: wdata16 = st_ff.p_cmp;
         OFS_S_COUNT: wdata16 = s_count;
         default: wdata16 = 16'h0000;
      endcase
      if (avs_byteenable[0]) begin
         wdata16[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
         wdata16[15:8] = avs_writedata[15:8];
      end
   end

   assign p_cnt_wr = wr_commit && avs_address == OFS_P_COUNT;
   assign s_cnt_wr = wr_commit && avs_address == OFS_S_COUNT;

   // secondary follows a primary A match when enabled
   assign s_clear = p_match && (st_ff.sync_clr[BIT_SYNC_ON_A]
      || (st_ff.sync_op[BIT_SYNC_P] && st_ff.sync_op[BIT_SYNC_S]));

   always_comb begin
      logic byte_wr;
      byte_wr = wr_commit && avs_byteenable[0];
      nxt_st = st_ff;
      nxt_st.adc = 1'b0;

      // unit rate dividers, gated by module stop bits
      nxt_st.fast_en = 1'b0;
      nxt_st.slow_en = 1'b0;
      if (st_ff.mod_stop[BIT_FAST_STOP]) begin
         nxt_st.fast_div = 3'h0;
      end else if (st_ff.fast_div >= div_last(st_ff.clk_div[FAST_DIV_LSB +: 3])) begin
         nxt_st.fast_div = 3'h0;
         nxt_st.fast_en = 1'b1;
      end else begin
         nxt_st.fast_div = st_ff.fast_div + 3'h1;
      end
      if (st_ff.mod_stop[BIT_SLOW_STOP]) begin
         nxt_st.slow_div = 3'h0;
      end else if (st_ff.slow_div >= div_last(st_ff.clk_div[SLOW_DIV_LSB +: 3])) begin
         nxt_st.slow_div = 3'h0;
         nxt_st.slow_en = 1'b1;
      end else begin
         nxt_st.slow_div = st_ff.slow_div + 3'h1;
      end

      // bus handshake: one wait cycle, then commit
      if ((avs_read || avs_write) && st_ff.wreq) begin
         nxt_st.wreq = 1'b0;
         case (avs_address)
            OFS_CLK_DIV: nxt_st.rdata = {16'h0000, st_ff.clk_div};
            OFS_MOD_STOP: nxt_st.rdata = {24'h000000, st_ff.mod_stop};
            OFS_P_CTRL: nxt_st.rdata = {24'h000000, st_ff.p_ctrl};
            OFS_P_MODE: nxt_st.rdata = {24'h000000, st_ff.p_mode};
            OFS_P_COUNT: nxt_st.rdata = {16'h0000, p_count};
            OFS_P_CMP_A: nxt_st.rdata = {16'h0000, st_ff.p_cmp};
            OFS_P_IO_HI: nxt_st.rdata = {24'h000000, st_ff.p_io_hi};
            OFS_P_IO_LO: nxt_st.rdata = {24'h000000, st_ff.p_io_lo};
            OFS_P_IE: nxt_st.rdata = {24'h000000, st_ff.p_ie};
            OFS_P_IE2: nxt_st.rdata = {24'h000000, st_ff.p_ie2};
            OFS_SLOW_START: nxt_st.rdata = {24'h000000, st_ff.slow_start};
            OFS_P_STATUS: nxt_st.rdata = {27'h0000000, st_ff.flag_ovf, 3'h0, st_ff.flag_a};
            OFS_S_CTRL: nxt_st.rdata = {24'h000000, st_ff.s_ctrl};
            OFS_S_MODE: nxt_st.rdata = {24'h000000, st_ff.s_mode};
            OFS_S_COUNT: nxt_st.rdata = {16'h0000, s_count};
            OFS_FAST_START: nxt_st.rdata = {24'h000000, st_ff.fast_start};
            OFS_SYNC_CLR: nxt_st.rdata = {24'h000000, st_ff.sync_clr};
            OFS_SYNC_OP: nxt_st.rdata = {24'h000000, st_ff.sync_op};
            default: nxt_st.rdata = 32'h00000000;
         endcase
      end else if (commit) begin
         nxt_st.wreq = 1'b1;
      end

      // reading a set flag arms its clear
      if (rd_commit && avs_address == OFS_P_STATUS) begin
         nxt_st.arm_a = st_ff.flag_a;
         nxt_st.arm_ovf = st_ff.flag_ovf;
      end

      if (wr_commit) begin
         case (avs_address)
            OFS_CLK_DIV: nxt_st.clk_div = wdata16 & MASK_CLK_DIV;
            OFS_P_CMP_A: nxt_st.p_cmp = wdata16;
            default: nxt_st.clk_div = st_ff.clk_div;
         endcase
      end
      if (byte_wr) begin
         case (avs_address)
            OFS_MOD_STOP: nxt_st.mod_stop = wdata8;
            OFS_P_CTRL: nxt_st.p_ctrl = wdata8;
            OFS_P_MODE: nxt_st.p_mode = wdata8 & MASK_P_MODE;
            OFS_P_IO_HI: nxt_st.p_io_hi = wdata8;
            OFS_P_IO_LO: nxt_st.p_io_lo = wdata8;
            OFS_P_IE: nxt_st.p_ie = wdata8 & MASK_P_IE;
            OFS_P_IE2: nxt_st.p_ie2 = wdata8 & MASK_P_IE2;
            OFS_SLOW_START: nxt_st.slow_start = wdata8 & MASK_SLOW_START;
            OFS_P_STATUS: begin
               if (st_ff.arm_a && !wdata8[BIT_FLAG_A]) begin
                  nxt_st.flag_a = 1'b0;
               end
               if (st_ff.arm_ovf && !wdata8[BIT_FLAG_OVF]) begin
                  nxt_st.flag_ovf = 1'b0;
               end
               nxt_st.arm_a = 1'b0;
               nxt_st.arm_ovf = 1'b0;
            end
            OFS_S_CTRL: nxt_st.s_ctrl = wdata8;
            OFS_S_MODE: nxt_st.s_mode = wdata8 & MASK_S_MODE;
            OFS_FAST_START: nxt_st.fast_start = wdata8 & MASK_FAST_START;
            OFS_SYNC_CLR: nxt_st.sync_clr = wdata8;
            OFS_SYNC_OP: nxt_st.sync_op = wdata8 & MASK_SYNC_OP;
            default: nxt_st.sync_op = st_ff.sync_op;
         endcase
      end

      // hardware set wins over a software clear
      if (p_match) begin
         nxt_st.flag_a = 1'b1;
         nxt_st.adc = st_ff.p_ie[BIT_IE_ADC];
      end
      if (p_ovf) begin
         nxt_st.flag_ovf = 1'b1;
      end
      nxt_st.irq_a = nxt_st.flag_a && st_ff.p_ie[BIT_IE_CMP_A];
      nxt_st.irq_ovf = nxt_st.flag_ovf && st_ff.p_ie[BIT_IE_OVF];
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_ff <= '0;
         st_ff.wreq <= 1'b1;
         st_ff.clk_div <= RST_CLK_DIV;
         st_ff.mod_stop <= RST_MOD_STOP;
         st_ff.p_cmp <= RST_CMP;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // primary channel on the slow unit rate
   cts_channel u_primary (
      .clk(clk),
      .sys_rst(sys_rst),
      .unit_en(st_ff.slow_en),
      .run(st_ff.slow_start[BIT_RUN_CH0]),
      .ctrl(st_ff.p_ctrl),
      .mode(st_ff.p_mode),
      .cmp_a(st_ff.p_cmp),
      .sync_clear(1'b0),
      .cnt_wr(p_cnt_wr),
      .cnt_wdata(wdata16),
      .count(p_count),
      .match(p_match),
      .overflow(p_ovf)
   );

   // secondary channel on the fast unit rate, no compare register
   cts_channel u_secondary (
      .clk(clk),
      .sys_rst(sys_rst),
      .unit_en(st_ff.fast_en),
      .run(st_ff.fast_start[BIT_RUN_CH4]),
      .ctrl(st_ff.s_ctrl),
      .mode(st_ff.s_mode),
      .cmp_a(RST_CMP),
      .sync_clear(s_clear),
      .cnt_wr(s_cnt_wr),
      .cnt_wdata(wdata16),
      .count(s_count),
      .match(),
      .overflow()
   );

   assign avs_readdata = st_ff.rdata;
   assign avs_waitrequest = st_ff.wreq;
   assign compare_a_irq = st_ff.irq_a;
   assign overflow_irq = st_ff.irq_ovf;
   assign adc_start = st_ff.adc;
endmodule : cts_top

// ---- hw/cts_pkg.sv ----
// constants, field layout and helpers for the compare timer pair
// assumes one 200 MHz clock and a synchronous active-high reset
// What this block does
// - clear source 001 clears counter on A match
// - edge select 00 counts each count tick
// - primary prescale 011 divides slow clock by 64
// - secondary prescale 100 divides clock by 256
// - clear source 011 clears secondary on primary A match; primary never clears
// - sync bit 1 puts channel in sync operation
// - mode 0000 is normal counting
// - buffer bits 0 mean unbuffered pairs
// - io field 0000 means compare, pin holds
// - enable bits: overflow 4, compares 3-0, trigger 7
// - compare A request needs flag and enable 0
// - second enable: trigger 7, F 1, E 0
// - bits 5 and 6 of primary enable reserved
// - start register run bits, 0x01 runs channel 0
// - divider code 000 is x1, 001 is x1/2
// - stop bit 1 gates unit clock, 7 fast 6 slow
// - sync clear bit 7 clears on A flag
// - fast start bit 7 runs secondary counter
package cts_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CLK_DIV = 8'h00;
   localparam logic [7:0] OFS_MOD_STOP = 8'h04;
   localparam logic [7:0] OFS_P_CTRL = 8'h08;
   localparam logic [7:0] OFS_P_MODE = 8'h0c;
   localparam logic [7:0] OFS_P_COUNT = 8'h10;
   localparam logic [7:0] OFS_P_CMP_A = 8'h14;
   localparam logic [7:0] OFS_P_IO_HI = 8'h18;
   localparam logic [7:0] OFS_P_IO_LO = 8'h1c;
   localparam logic [7:0] OFS_P_IE = 8'h20;
   localparam logic [7:0] OFS_P_IE2 = 8'h24;
   localparam logic [7:0] OFS_SLOW_START = 8'h28;
   localparam logic [7:0] OFS_P_STATUS = 8'h2c;
   localparam logic [7:0] OFS_S_CTRL = 8'h30;
   localparam logic [7:0] OFS_S_MODE = 8'h34;
   localparam logic [7:0] OFS_S_COUNT = 8'h38;
   localparam logic [7:0] OFS_FAST_START = 8'h3c;
   localparam logic [7:0] OFS_SYNC_CLR = 8'h40;
   localparam logic [7:0] OFS_SYNC_OP = 8'h44;
   // writable bit masks, reserved bits stay zero
   localparam logic [15:0] MASK_CLK_DIV = 16'h7fff;
   localparam logic [7:0] MASK_P_MODE = 8'h7f;
   localparam logic [7:0] MASK_S_MODE = 8'h3f;
   localparam logic [7:0] MASK_P_IE = 8'h9f;
   localparam logic [7:0] MASK_P_IE2 = 8'h83;
   localparam logic [7:0] MASK_SLOW_START = 8'hc7;
   localparam logic [7:0] MASK_FAST_START = 8'hc0;
   localparam logic [7:0] MASK_SYNC_OP = 8'h11;
   // reset values
   localparam logic [15:0] RST_CLK_DIV = 16'h0000;
   localparam logic [7:0] RST_MOD_STOP = 8'hff;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_CMP = 16'hffff;
   // field positions
   localparam int CLR_LSB = 5;
   localparam int EDGE_LSB = 3;
   localparam int PSC_LSB = 0;
   localparam int MODE_LSB = 0;
   localparam int FAST_DIV_LSB = 3;
   localparam int SLOW_DIV_LSB = 0;
   localparam int BIT_FAST_STOP = 7;
   localparam int BIT_SLOW_STOP = 6;
   localparam int BIT_RUN_CH0 = 0;
   localparam int BIT_RUN_CH4 = 7;
   localparam int BIT_SYNC_ON_A = 7;
   localparam int BIT_SYNC_P = 0;
   localparam int BIT_SYNC_S = 4;
   localparam int BIT_IE_CMP_A = 0;
   localparam int BIT_IE_OVF = 4;
   localparam int BIT_IE_ADC = 7;
   localparam int BIT_FLAG_A = 0;
   localparam int BIT_FLAG_OVF = 4;
   // field codes
   localparam logic [2:0] CLR_NONE = 3'h0;
   localparam logic [2:0] CLR_CMP_A = 3'h1;
   localparam logic [2:0] CLR_SYNC = 3'h3;
   localparam logic [1:0] EDGE_RISING = 2'h0;
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [15:0] CMP_100MS_DIV64 = 16'hf423;
   localparam logic [15:0] COUNT_MAX = 16'hffff;

   // prescale terminal count for a select code
   function automatic logic [9:0] psc_last(input logic [2:0] sel);
      case (sel)
         3'h1: psc_last = 10'h003;
         3'h2: psc_last = 10'h00f;
         3'h3: psc_last = 10'h03f;
         3'h4: psc_last = 10'h0ff;
         3'h5: psc_last = 10'h3ff;
         default: psc_last = 10'h000;
      endcase
   endfunction : psc_last

   // unit divider terminal count for a divider code
   function automatic logic [2:0] div_last(input logic [2:0] code);
      case (code)
         3'h0: div_last = 3'h0;
         3'h1: div_last = 3'h1;
         3'h2: div_last = 3'h3;
         default: div_last = 3'h7;
      endcase
   endfunction : div_last
endpackage : cts_pkg

// ---- hw/cts_channel.sv ----
// one 16-bit timer channel with prescaler and clear sources
// assumes unit_en is a one-cycle rate pulse on the shared clock
`timescale 1ns/1ps
module cts_channel
   import cts_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic unit_en,
   input wire logic run,
   input wire logic [7:0] ctrl,
   input wire logic [7:0] mode,
   input wire logic [15:0] cmp_a,
   input wire logic sync_clear,
   input wire logic cnt_wr,
   input wire logic [15:0] cnt_wdata,
   output logic [15:0] count,
   output logic match,
   output logic overflow
);
   typedef struct packed {
      logic [9:0] pre;
      logic [15:0] count;
      logic match;
      logic overflow;
   } cts_chan_state_type;

   cts_chan_state_type st_ff;
   cts_chan_state_type nxt_st;

   always_comb begin
      logic tick;
      tick = 1'b0;
      nxt_st = st_ff;
      nxt_st.match = 1'b0;
      nxt_st.overflow = 1'b0;
      // prescaler on the unit rate
      if (unit_en && run) begin
         if (st_ff.pre >= psc_last(ctrl[PSC_LSB +: 3])) begin
            nxt_st.pre = 10'h000;
            tick = 1'b1;
         end else begin
            nxt_st.pre = st_ff.pre + 10'h001;
         end
      end
      if (sync_clear && ctrl[CLR_LSB +: 3] == CLR_SYNC) begin
         nxt_st.count = 16'h0000;
      end else if (tick && mode[MODE_LSB +: 4] == MODE_NORMAL
            && ctrl[EDGE_LSB +: 2] == EDGE_RISING) begin
         if (st_ff.count == cmp_a) begin
            nxt_st.match = 1'b1;
         end
         if (st_ff.count == cmp_a && ctrl[CLR_LSB +: 3] == CLR_CMP_A) begin
            nxt_st.count = 16'h0000;
         end else begin
            nxt_st.overflow = (st_ff.count == COUNT_MAX);
            nxt_st.count = st_ff.count + 16'h0001;
         end
      end
      if (cnt_wr) begin
         nxt_st.count = cnt_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign count = st_ff.count;
   assign match = st_ff.match;
   assign overflow = st_ff.overflow;
endmodule : cts_channel

// ---- test/cts_top_properties.sv ----
// assertions on the ports of the compare timer top
// assumes avalon-mm requests held until waitrequest is sampled low
`timescale 1ns/1ps
module cts_top_properties
   import cts_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic compare_a_irq,
   input wire logic overflow_irq,
   input wire logic adc_start
);
   logic [7:0] ie_ff;
   logic rd_done;
   assign rd_done = avs_read && !avs_waitrequest;
   // shadow of the interrupt enable register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ie_ff <= 8'h00;
      end else if (avs_write && !avs_waitrequest && avs_address == OFS_P_IE
            && avs_byteenable[0]) begin
         ie_ff <= avs_writedata[7:0];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for two cycles");
   chk_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("request not answered next cycle");
   chk_reset_quiet: assert property ($fell(sys_rst) |-> avs_waitrequest && !compare_a_irq
      && !overflow_irq && !adc_start && avs_readdata == 32'h0)
      else $error("outputs not idle after reset");
   chk_irq_follow: assert property (adc_start && ie_ff[0] |-> ##[1:2] compare_a_irq)
      else $error("compare irq missing after match");
   chk_irq_mask: assert property (!ie_ff[0] && !$past(ie_ff[0]) |-> !compare_a_irq)
      else $error("compare irq while disabled");
   chk_ovf_mask: assert property (overflow_irq |-> ie_ff[4] || $past(ie_ff[4]))
      else $error("overflow irq while disabled");
   chk_adc_enable: assert property ($rose(adc_start) |-> $past(ie_ff[7]))
      else $error("adc start while disabled");
   chk_unmapped_zero: assert property (rd_done && avs_address > OFS_SYNC_OP
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
   chk_ie_readback: assert property (rd_done && avs_address == OFS_P_IE
      |-> avs_readdata == {24'h0, ie_ff & 8'h9f}) else $error("enable readback wrong");
endmodule : cts_top_properties

bind cts_top cts_top_properties chk (.clk, .sys_rst, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
   .compare_a_irq, .overflow_irq, .adc_start);

// ---- test/cts_top_tb_top.sv ----
// self-checking bench for the compare timer top
// assumes the package and design compiled first; one 200 mhz clock
`timescale 1ns/1ps
module cts_top_tb_top
   import cts_pkg::*;
   ;
   logic clk;
   logic sys_rst;
   logic [7:0] avs_address;
   logic avs_read, avs_write;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic avs_waitrequest, compare_a_irq, overflow_irq, adc_start;
   int failures = 0, compares = 0, cyc = 0, t0;
   logic [31:0] d, e;
   // register table: offset, reset value, bits kept after writing ones
   logic [7:0] ra [14] = '{OFS_CLK_DIV, OFS_MOD_STOP, OFS_P_CTRL, OFS_P_MODE,
      OFS_P_CMP_A, OFS_P_IO_HI, OFS_P_IE, OFS_P_IE2, OFS_SLOW_START, OFS_S_MODE,
      OFS_FAST_START, OFS_SYNC_OP, 8'h80, 8'h48};
   logic [15:0] rv [14] = '{1: 16'h00ff, 4: 16'hffff, default: 16'h0000};
   logic [15:0] rm [14] = '{16'h7fff, 16'h00ff, 16'h00ff, 16'h007f, 16'hffff,
      16'h00ff, 16'h009f, 16'h0083, 16'h00c7, 16'h003f, 16'h00c0, 16'h0011,
      16'h0000, 16'h0000};
   // timer setup sequence
   logic [7:0] sa [11] = '{OFS_MOD_STOP, OFS_CLK_DIV, OFS_P_CTRL, OFS_P_CMP_A,
      OFS_P_COUNT, OFS_P_IE, OFS_S_CTRL, OFS_S_COUNT, OFS_SYNC_CLR, OFS_FAST_START,
      OFS_SLOW_START};
   logic [15:0] sv [11] = '{16'h003f, 16'h0241, 16'h0023, 16'h0003, 16'h0000,
      16'h0081, 16'h0064, 16'h0000, 16'h0080, 16'h0080, 16'h0001};
   logic [7:0] yc [3] = '{8'h80, 8'h00, 8'h00};
   logic [7:0] yo [3] = '{8'h00, 8'h11, 8'h00};
   // stop control: register, stop value, run value, counter watched
   logic [7:0] pa [3] = '{OFS_FAST_START, OFS_SLOW_START, OFS_MOD_STOP};
   logic [7:0] pv [3] = '{8'h00, 8'h00, 8'h7f};
   logic [7:0] pr [3] = '{8'h80, 8'h01, 8'h3f};
   logic [7:0] pc [3] = '{OFS_S_COUNT, OFS_P_COUNT, OFS_P_COUNT};

   cts_top uut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .compare_a_irq, .overflow_irq,
      .adc_start);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) cyc <= cyc + 1;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      avs_address <= a;
      avs_writedata <= v;
      avs_write <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      v = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : rd

   task automatic wait_adc;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (adc_start !== 1'b1 && n < 1000);
      chk("adc_start", {31'h0, adc_start}, 32'h1);
   endtask : wait_adc

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up

   // watchdog, about ten times the expected run
   initial begin
      #300000;
      failures++;
      wrap_up();
   end

   initial begin
      sys_rst = 1'b1;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      for (int k = 0; k < 14; k++) begin
         rd(ra[k], d);
         chk("reset value", d, {16'h0, rv[k]});
         wr(ra[k], (ra[k] == OFS_P_IE) ? 32'hffffff9f : 32'hffffffff);
         rd(ra[k], d);
         chk("writable bits", d, {16'h0, rm[k]});
         wr(ra[k], {16'h0, rv[k]});
      end
      $display("test registers done");
      wr(OFS_P_CMP_A, {16'h0, CMP_100MS_DIV64});
      rd(OFS_P_CMP_A, d);
      chk("period value", d, 32'h0000f423);
      for (int k = 0; k < 11; k++) begin
         wr(sa[k], {16'h0, sv[k]});
      end
      wait_adc();
      t0 = cyc;
      wait_adc();
      chk("match period", 32'(cyc - t0), 32'h200);
      rd(OFS_P_COUNT, d);
      chk("primary count", d, 32'h0);
      chk("compare irq", {31'h0, compare_a_irq}, 32'h1);
      rd(OFS_P_STATUS, d);
      chk("match flag", d & 32'h1, 32'h1);
      wr(OFS_P_STATUS, 32'h0);
      repeat (2) @(posedge clk);
      chk("irq cleared", {31'h0, compare_a_irq}, 32'h0);
      $display("test compare done");
      for (int k = 0; k < 3; k++) begin
         wr(OFS_SYNC_CLR, {24'h0, yc[k]});
         wr(OFS_SYNC_OP, {24'h0, yo[k]});
         wait_adc();
         wait_adc();
         rd(OFS_S_COUNT, d);
         chk("secondary cleared", {31'h0, d === 32'h0}, {31'h0, k < 2});
      end
      $display("test sync clear done");
      wr(OFS_P_IE, 32'h80);
      rd(OFS_P_STATUS, d);
      wr(OFS_P_STATUS, 32'h0);
      wait_adc();
      repeat (3) @(posedge clk);
      chk("masked irq", {31'h0, compare_a_irq}, 32'h0);
      rd(OFS_P_STATUS, d);
      chk("flag while masked", d & 32'h1, 32'h1);
      $display("test mask done");
      for (int k = 0; k < 3; k++) begin
         wr(pa[k], {24'h0, pv[k]});
         rd(pc[k], e);
         repeat (300) @(posedge clk);
         rd(pc[k], d);
         chk("held count", d, e);
         wr(pa[k], {24'h0, pr[k]});
      end
      $display("test stop done");
      // free-running count from just below the top, overflow enabled
      wr(OFS_P_CTRL, 32'h0);
      wr(OFS_P_IE, 32'h10);
      wr(OFS_P_COUNT, 32'hfff8);
      repeat (40) @(posedge clk);
      chk("overflow irq", {31'h0, overflow_irq}, 32'h1);
      rd(OFS_P_STATUS, d);
      chk("overflow flag", d & 32'h10, 32'h10);
      wr(OFS_P_STATUS, 32'h0);
      repeat (2) @(posedge clk);
      chk("overflow cleared", {31'h0, overflow_irq}, 32'h0);
      $display("test overflow done");
      wrap_up();
   end
endmodule : cts_top_tb_top
